// ==== core/eeprom_host_pkg.sv ====
// constants, command codes and timing for the two-wire memory controller
// assumes a 50 MHz core clock and an open-drain two-wire bus with pull-ups
package eeprom_host_pkg;

  // ****************************************************************
  // core clock and bus timing
  // ****************************************************************
  localparam int CORE_CLK_KHZ = 50000;
  localparam int SCL_KHZ_LOW_VOLT = 400;
  localparam int SCL_KHZ_HIGH_VOLT = 1000;
  localparam int WRITE_TIME_MS = 5;
  localparam int WRITE_CYCLES = CORE_CLK_KHZ * WRITE_TIME_MS;

  // ****************************************************************
  // address word and array layout
  // ****************************************************************
  localparam logic [3:0] DEV_TYPE_CODE = 4'h_a;
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_COUNT = 512;
  localparam int WORD_ADDR_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] ACK_SLOT = 4'h_8;
  localparam logic [1:0] QUARTER_LAST = 2'h_3;
  localparam logic [1:0] QUARTER_SAMPLE = 2'h_2;

  // ****************************************************************
  // commands
  // ****************************************************************
  typedef enum logic [2:0] {
    op_write = 3'h_0,
    op_random_read = 3'h_1,
    op_current_read = 3'h_2,
    op_poll = 3'h_3,
    op_recover = 3'h_4
  } op_type;

endpackage : eeprom_host_pkg

// ==== core/eeprom_read_buffer.sv ====
// two-entry buffer between the serial receiver and the read data stream
// assumes a push only happens while in_ready is high
`timescale 1ns/10ps
`default_nettype none
module eeprom_read_buffer #(
  parameter int width = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);

  logic [width-1:0] tail_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  initial begin
    if (width < 1) $error("width must be at least one");
  end

  assign in_ready = (count_reg != 2'h_2);
  assign out_valid = (count_reg != 2'h_0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ****************************************************************
  // occupancy
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count_reg <= 2'h_0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 2'h_1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 2'h_1;
    end
  end

  // ****************************************************************
  // storage, head word drives the output directly
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      out_data <= '0;
      tail_reg <= '0;
    end else begin
      if (pop) begin
        out_data <= (count_reg == 2'h_2) ? tail_reg : in_data;
        if (count_reg == 2'h_2 && push) begin
          tail_reg <= in_data;
        end
      end else if (push) begin
        if (count_reg == 2'h_0) begin
          out_data <= in_data;
        end else begin
          tail_reg <= in_data;
        end
      end
    end
  end

endmodule : eeprom_read_buffer
`default_nettype wire

// ==== core/eeprom_host.sv ====
// bus controller for a two-wire serial memory with strapped select inputs
// assumes open-drain SCL/SDA with pull-ups; sda_in is asynchronous to core_clk
//
// Overview of operation
// - start is SDA falling while SCL high; every command opens with one
// - stop is SDA rising while SCL high; ends each command
// - SDA changes only while SCL low except start and stop
// - device address word opens with the fixed one-zero type pattern
// - eighth address bit high reads, low writes
// - byte write: address, two word-address bytes, one data byte, stop
// - page write sends up to 128 data bytes before the stop
// - poll with start and address word until the memory acknowledges
// - current read: address word, data byte, no acknowledge, stop
// - random read: dummy write of address, repeated start, read
// - sequential read: acknowledge each byte, omit it on the last
// - recovery: start, nine clocks, start, stop
// - SCL stays at or below 400 kHz or 1000 kHz
// - inputs sampled on SCL rise, outputs change after SCL fall
`timescale 1ns/10ps
`default_nettype none
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter int scl_khz = SCL_KHZ_LOW_VOLT,
  parameter int write_cycles = WRITE_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire eeprom_host_pkg::op_type cmd_op,
  input wire logic [2:0] cmd_select,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_count,
  output logic cmd_busy,
  output logic cmd_done,
  output logic cmd_error,
  // write data stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  // read data stream
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  // write protect
  input wire logic protect_writes,
  output logic write_protect,
  // serial bus
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);
  import eeprom_host_pkg::*;

  localparam int QUARTER = (CORE_CLK_KHZ + 4 * scl_khz - 1) / (4 * scl_khz);
  localparam logic [15:0] QUARTER_TOP = 16'(QUARTER - 1);

  initial begin
    if (scl_khz < 1 || scl_khz > SCL_KHZ_HIGH_VOLT) $error("scl_khz range");
    if (QUARTER > 65536) $error("scl_khz too low for quarter counter");
    if (write_cycles < 1) $error("write_cycles must be positive");
  end

  typedef enum {
    st_idle, st_start, st_byte, st_stop, st_wait_data, st_wait_space
  } state_type;

  typedef enum {
    sq_dev_w, sq_addr_hi, sq_addr_lo, sq_wdata, sq_dev_r, sq_rdata,
    sq_poll, sq_recover
  } seq_type;

  function automatic logic [7:0] dev_word(input logic [2:0] sel,
                                          input logic rd);
    dev_word = {DEV_TYPE_CODE, sel, rd};
  endfunction : dev_word

  state_type state_reg;
  seq_type seq_reg;
  op_type op_reg;
  logic [2:0] sel_reg;
  logic [15:0] addr_reg;
  logic [7:0] remain_reg;
  logic [7:0] shift_reg;
  logic [7:0] rx_reg;
  logic [3:0] bit_reg;
  logic [15:0] qcnt_reg;
  logic [1:0] quarter_reg;
  logic nack_reg;
  logic err_reg;
  logic second_reg;
  logic [31:0] poll_cnt_reg;
  logic sda_meta_reg;
  logic sda_sync_reg;
  logic scl_low_reg;
  logic sda_low_reg;
  logic tick;
  logic prim_end;
  logic timer_run;
  logic rx_byte;
  logic bit_low;
  logic push;
  logic space;

  assign cmd_ready = (state_reg == st_idle);
  assign cmd_busy = (state_reg != st_idle);
  assign wr_ready = (state_reg == st_wait_data);
  assign timer_run = !(state_reg inside {st_idle, st_wait_data,
                                         st_wait_space});
  assign tick = timer_run && (qcnt_reg == QUARTER_TOP);
  assign prim_end = tick && (quarter_reg == QUARTER_LAST);
  assign rx_byte = (seq_reg == sq_rdata) || (seq_reg == sq_recover);
  assign push = prim_end && state_reg == st_byte && seq_reg == sq_rdata &&
                bit_reg == ACK_SLOT;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = !scl_low_reg;
  assign sda_oe_n = !sda_low_reg;

  // ****************************************************************
  // data bit to send in the current slot
  // ****************************************************************
  always_comb begin
    bit_low = 1'b0;
    if (bit_reg != ACK_SLOT) begin
      bit_low = !rx_byte && !shift_reg[7];
    end else if (seq_reg == sq_rdata) begin
      bit_low = (remain_reg != 8'h_01);
    end
  end

  // ****************************************************************
  // input synchroniser and write-protect pin
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      write_protect <= 1'b0;
    end else begin
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      write_protect <= protect_writes;
    end
  end

  // ****************************************************************
  // quarter-period timer, one bus slot is four quarters
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      qcnt_reg <= 16'h_0000;
      quarter_reg <= 2'h_0;
    end else if (!timer_run) begin
      qcnt_reg <= 16'h_0000;
      quarter_reg <= 2'h_0;
    end else if (tick) begin
      qcnt_reg <= 16'h_0000;
      quarter_reg <= quarter_reg + 2'h_1;
    end else begin
      qcnt_reg <= qcnt_reg + 16'h_0001;
    end
  end

  // ****************************************************************
  // pin drivers: SDA moves only in SCL low time, except at start and stop
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end else if (tick) begin
      case (state_reg)
        st_start: begin
          case (quarter_reg)
            2'h_0: begin
              scl_low_reg <= 1'b1;
              sda_low_reg <= 1'b0;
            end
            2'h_1: scl_low_reg <= 1'b0;
            2'h_2: sda_low_reg <= 1'b1;
            default: scl_low_reg <= 1'b1;
          endcase
        end
        st_stop: begin
          case (quarter_reg)
            2'h_0: begin
              scl_low_reg <= 1'b1;
              sda_low_reg <= 1'b1;
            end
            2'h_1: scl_low_reg <= 1'b0;
            2'h_2: sda_low_reg <= 1'b0;
            default: scl_low_reg <= 1'b0;
          endcase
        end
        st_byte: begin
          case (quarter_reg)
            2'h_0: begin
              scl_low_reg <= 1'b1;
              sda_low_reg <= bit_low;
            end
            2'h_1: scl_low_reg <= 1'b0;
            2'h_2: scl_low_reg <= 1'b0;
            default: scl_low_reg <= 1'b1;
          endcase
        end
        default: scl_low_reg <= scl_low_reg;
      endcase
    end
  end

  // ****************************************************************
  // sampling while SCL is high
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rx_reg <= 8'h_00;
      nack_reg <= 1'b0;
    end else if (tick && quarter_reg == QUARTER_SAMPLE &&
                 state_reg == st_byte) begin
      if (bit_reg == ACK_SLOT) begin
        nack_reg <= sda_sync_reg;
      end else begin
        rx_reg <= {rx_reg[6:0], sda_sync_reg};
      end
    end
  end

  // ****************************************************************
  // write-cycle wait limit while polling
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      poll_cnt_reg <= 32'h_0000_0000;
    end else if (seq_reg != sq_poll) begin
      poll_cnt_reg <= 32'h_0000_0000;
    end else if (poll_cnt_reg != 32'(write_cycles)) begin
      poll_cnt_reg <= poll_cnt_reg + 32'h_0000_0001;
    end
  end

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= st_idle;
      seq_reg <= sq_dev_w;
      op_reg <= op_write;
      sel_reg <= 3'h_0;
      addr_reg <= 16'h_0000;
      remain_reg <= 8'h_00;
      shift_reg <= 8'h_00;
      bit_reg <= 4'h_0;
      err_reg <= 1'b0;
      second_reg <= 1'b0;
      cmd_done <= 1'b0;
      cmd_error <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      case (state_reg)
        st_idle: begin
          if (cmd_valid) begin
            op_reg <= cmd_op;
            sel_reg <= cmd_select;
            addr_reg <= cmd_addr;
            err_reg <= 1'b0;
            second_reg <= 1'b0;
            remain_reg <= (cmd_count == 8'h_00) ? 8'h_01 : cmd_count;
            if (cmd_op == op_write && cmd_count > 8'(PAGE_BYTES)) begin
              remain_reg <= 8'(PAGE_BYTES);
            end
            case (cmd_op)
              op_current_read: seq_reg <= sq_dev_r;
              op_poll: seq_reg <= sq_poll;
              op_recover: seq_reg <= sq_recover;
              default: seq_reg <= sq_dev_w;
            endcase
            state_reg <= st_start;
          end
        end
        st_start: begin
          if (prim_end) begin
            bit_reg <= 4'h_0;
            state_reg <= st_byte;
            case (seq_reg)
              sq_dev_r: shift_reg <= dev_word(sel_reg, 1'b1);
              sq_recover: begin
                shift_reg <= 8'h_ff;
                if (second_reg) begin
                  state_reg <= st_stop;
                end
              end
              default: shift_reg <= dev_word(sel_reg, 1'b0);
            endcase
          end
        end
        st_wait_data: begin
          if (wr_valid) begin
            shift_reg <= wr_data;
            bit_reg <= 4'h_0;
            state_reg <= st_byte;
          end
        end
        st_wait_space: begin
          if (space) begin
            bit_reg <= 4'h_0;
            state_reg <= st_byte;
          end
        end
        st_byte: begin
          if (prim_end && bit_reg != ACK_SLOT) begin
            bit_reg <= bit_reg + 4'h_1;
            shift_reg <= {shift_reg[6:0], 1'b0};
          end else if (prim_end) begin
            if (!rx_byte && nack_reg && seq_reg != sq_poll) begin
              err_reg <= 1'b1;
              state_reg <= st_stop;
            end else begin
              case (seq_reg)
                sq_dev_w: begin
                  seq_reg <= sq_addr_hi;
                  shift_reg <= addr_reg[15:8];
                  bit_reg <= 4'h_0;
                end
                sq_addr_hi: begin
                  seq_reg <= sq_addr_lo;
                  shift_reg <= addr_reg[7:0];
                  bit_reg <= 4'h_0;
                end
                sq_addr_lo: begin
                  if (op_reg == op_write) begin
                    seq_reg <= sq_wdata;
                    state_reg <= st_wait_data;
                  end else begin
                    seq_reg <= sq_dev_r;
                    state_reg <= st_start;
                  end
                end
                sq_dev_r: begin
                  seq_reg <= sq_rdata;
                  state_reg <= st_wait_space;
                end
                sq_wdata, sq_rdata: begin
                  remain_reg <= remain_reg - 8'h_01;
                  if (remain_reg == 8'h_01) begin
                    state_reg <= st_stop;
                  end else if (seq_reg == sq_wdata) begin
                    state_reg <= st_wait_data;
                  end else begin
                    state_reg <= st_wait_space;
                  end
                end
                sq_recover: begin
                  second_reg <= 1'b1;
                  state_reg <= st_start;
                end
                default: state_reg <= st_stop;
              endcase
            end
          end
        end
        st_stop: begin
          if (prim_end) begin
            if (seq_reg == sq_wdata && !err_reg) begin
              seq_reg <= sq_poll;
              state_reg <= st_start;
            end else if (seq_reg == sq_poll && nack_reg &&
                         poll_cnt_reg != 32'(write_cycles)) begin
              state_reg <= st_start;
            end else begin
              cmd_done <= 1'b1;
              cmd_error <= err_reg || (seq_reg == sq_poll && nack_reg);
              state_reg <= st_idle;
            end
          end
        end
        default: state_reg <= st_idle;
      endcase
    end
  end

  // ****************************************************************
  // read data buffer
  // ****************************************************************
  eeprom_read_buffer #(
    .width(BYTE_BITS)
  ) read_buffer (
    .core_clk(core_clk),
    .reset(reset),
    .in_valid(push),
    .in_ready(space),
    .in_data(rx_reg),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

endmodule : eeprom_host
`default_nettype wire

// ==== verification/eeprom_host_monitor.sv ====
// assertions on the ports of the two-wire memory host
// assumes the bus wire level follows the host enables while idle
`timescale 1ns/10ps
`default_nettype none
module eeprom_host_monitor
  import eeprom_host_pkg::*;
#(
  parameter int scl_khz = SCL_KHZ_LOW_VOLT,
  parameter int write_cycles = WRITE_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // command
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_busy,
  input wire logic cmd_done,
  // read stream and protect
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [7:0] rd_data,
  input wire logic protect_writes,
  input wire logic write_protect,
  // bus enables
  input wire logic scl_oe_n,
  input wire logic sda_oe_n
);
  // ****************************************************************
  // clock high time and period counters
  // ****************************************************************
  localparam int q = (CORE_CLK_KHZ + 4 * scl_khz - 1) / (4 * scl_khz);
  localparam int min_period = CORE_CLK_KHZ / scl_khz;
  logic [15:0] high_reg;
  logic [15:0] period_reg;
  logic scl_prev_reg;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) high_reg <= 16'h_ffff; // idle bus counts as a long high
    else if (!scl_oe_n) high_reg <= 16'h_0000;
    else if (high_reg != 16'h_ffff) high_reg <= high_reg + 16'h_0001;
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) scl_prev_reg <= 1'b1;
    else scl_prev_reg <= scl_oe_n;
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) period_reg <= 16'h_ffff;
    else if (scl_oe_n && !scl_prev_reg) period_reg <= 16'h_0001;
    else if (period_reg != 16'h_ffff) period_reg <= period_reg + 16'h_0001;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_sda_quiet_high: assert property (
    $changed(sda_oe_n) && scl_oe_n |-> high_reg >= 16'(q / 2))
    else $error("data line moved early in clock high");
  a_start_hold: assert property (
    $fell(sda_oe_n) && scl_oe_n |=> scl_oe_n [*8])
    else $error("clock fell too soon after start");
  a_stop_free: assert property (
    $rose(sda_oe_n) && scl_oe_n |=> (scl_oe_n && sda_oe_n) [*8])
    else $error("bus not left free after stop");
  a_scl_high_width: assert property (
    $fell(scl_oe_n) |-> high_reg >= 16'(2 * q - 2))
    else $error("clock high phase too short");
  a_scl_period: assert property (
    $rose(scl_oe_n) |-> period_reg >= 16'(min_period))
    else $error("clock period too short");
  a_idle_released: assert property (
    !cmd_busy |-> scl_oe_n && sda_oe_n)
    else $error("bus held while idle");
  a_done_pulse: assert property (cmd_done |-> cmd_ready ##1 !cmd_done)
    else $error("done not a single idle pulse");
  a_take_busy: assert property (cmd_valid && cmd_ready |=> cmd_busy)
    else $error("accepted command left host idle");
  a_rd_hold: assert property (
    rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("read byte lost while stalled");
  a_wp_copy: assert property (
    1'b1 |=> write_protect == $past(protect_writes))
    else $error("protect pin does not follow request");
endmodule : eeprom_host_monitor
bind eeprom_host eeprom_host_monitor #(
  .scl_khz(scl_khz),
  .write_cycles(write_cycles)
) eeprom_host_monitor_i (
  .core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_busy(cmd_busy), .cmd_done(cmd_done),
  .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
  .protect_writes(protect_writes), .write_protect(write_protect),
  .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n)
);
`default_nettype wire

// ==== verification/eeprom_model.sv ====
// behavioural two-wire serial memory facing the host
// assumes the bench resolves the open-drain wires with pull-ups
`timescale 1ns/10ps
`default_nettype none
module eeprom_model #(
  parameter int busy_ns = 30000
) (
  // bus, straps and protect
  input wire logic scl,
  input wire logic sda,
  input wire logic [2:0] straps,
  input wire logic wp,
  output logic sda_oe_n
);
  // ****************************************************************
  // array, pointer and transfer state
  // ****************************************************************
  logic [7:0] mem [0:65535];
  logic [15:0] ptr = 16'h_0000;
  logic [7:0] shift, hi, rd;
  logic [23:0] pend [$];
  logic busy = 1'b0;
  logic active = 1'b0;
  logic load = 1'b0;
  int bits = 0;
  int phase = 0;
  initial begin
    sda_oe_n = 1'b1;
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'h_5a;
  end
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b1;
      phase = 0;
      bits = 0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b0;
      if (pend.size() > 0) busy = 1'b1;
      foreach (pend[i]) mem[pend[i][23:8]] = pend[i][7:0];
      pend.delete();
    end
  end
  always @(posedge busy) begin
    #(busy_ns);
    busy = 1'b0;
  end
  always @(posedge scl) begin
    if (active && bits < 8) begin
      shift = {shift[6:0], sda};
      bits++;
    end else if (active && bits == 8) begin
      if (phase == 4 && sda !== 1'b0) active = 1'b0;
      load = (phase == 4) && active;
      bits++;
    end
  end
  always @(negedge scl) begin
    if (!active) sda_oe_n = 1'b1;
    else if (bits == 8 && phase != 4) begin
      sda_oe_n = 1'b0;
      case (phase)
        0: begin
          if (shift[7:4] == 4'h_a && shift[3:1] == straps && !busy) begin
            phase = shift[0] ? 4 : 1;
          end else begin
            sda_oe_n = 1'b1;
            active = 1'b0;
          end
        end
        1: begin
          hi = shift;
          phase = 2;
        end
        2: begin
          ptr = {hi, shift};
          phase = 3;
        end
        default: begin
          if (!wp) pend.push_back({ptr, shift});
          ptr[6:0] = ptr[6:0] + 7'h_01;
        end
      endcase
    end else if (bits == 8) sda_oe_n = 1'b1;
    else if (bits == 9) begin
      bits = 0;
      sda_oe_n = 1'b1;
      if (load) begin
        rd = mem[ptr];
        ptr = ptr + 16'h_0001;
        sda_oe_n = rd[7];
      end
    end else if (phase == 4 && bits > 0) sda_oe_n = rd[7 - bits];
  end
endmodule : eeprom_model
`default_nettype wire

// ==== verification/eeprom_host_tb.sv ====
// self-checking bench for the two-wire memory host
// assumes the behavioural memory model and the bound monitor
`timescale 1ns/10ps
`default_nettype none
module eeprom_host_tb;
  import eeprom_host_pkg::*;
  // ****************************************************************
  // signals, model and design
  // ****************************************************************
  localparam logic [2:0] strap = 3'h_5;
  logic core_clk = 1'b0;
  logic reset;
  logic cmd_valid = 1'b0;
  op_type cmd_op = op_write;
  logic [2:0] cmd_select = strap;
  logic [15:0] cmd_addr = 16'h_0000;
  logic [7:0] cmd_count = 8'h_01;
  logic cmd_ready, cmd_busy, cmd_done, cmd_error, err;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h_00;
  logic rd_ready = 1'b0;
  logic protect_writes = 1'b0;
  logic wr_ready, rd_valid, write_protect;
  logic [7:0] rd_data;
  logic scl_oe_n, sda_oe_n, mem_oe_n;
  wire logic sda = sda_oe_n & mem_oe_n;
  int bad_count = 0;
  int check_count = 0;
  logic [7:0] shadow [logic [15:0]];
  logic [7:0] got [$];
  logic [7:0] sent [$];
  eeprom_model eeprom_model_i (.scl(scl_oe_n), .sda(sda), .straps(strap),
    .wp(write_protect), .sda_oe_n(mem_oe_n));
  eeprom_host #(.scl_khz(1000), .write_cycles(4000)) eeprom_host_i (
    .core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_select(cmd_select),
    .cmd_addr(cmd_addr), .cmd_count(cmd_count), .cmd_busy(cmd_busy),
    .cmd_done(cmd_done), .cmd_error(cmd_error), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data),
    .protect_writes(protect_writes), .write_protect(write_protect),
    .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(),
    .sda_oe_n(sda_oe_n));
  initial forever #10 core_clk = ~core_clk;
  function automatic logic [7:0] expect_at(input logic [15:0] a);
    if (shadow.exists(a)) return shadow[a];
    return a[7:0] ^ a[15:8] ^ 8'h_5a;
  endfunction : expect_at
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  // one command; wr stream fed from sent, read bytes land in got
  task automatic run(input op_type op, input logic [2:0] sel,
                     input logic [15:0] a, input logic [7:0] n,
                     input int stall);
    logic taken, fw, fr, done;
    logic [7:0] rv;
    got.delete();
    cmd_op = op;
    cmd_select = sel;
    cmd_addr = a;
    cmd_count = n;
    cmd_valid = 1'b1;
    done = 1'b0;
    for (int g = 0; g < 60000 && !done; g++) begin
      wr_valid = sent.size() > 0;
      wr_data = wr_valid ? sent[0] : 8'h_00;
      rd_ready = g > stall && $urandom_range(3) != 0;
      @(negedge core_clk);
      taken = cmd_valid && cmd_ready;
      fw = wr_valid && wr_ready;
      fr = rd_valid && rd_ready;
      rv = rd_data;
      done = cmd_done;
      err = cmd_error;
      @(posedge core_clk);
      #1;
      if (taken) cmd_valid = 1'b0;
      if (fw) void'(sent.pop_front());
      if (fr) got.push_back(rv);
    end
    if (done !== 1'b1) check(8'h_00, 8'h_01);
  endtask : run
  task automatic write_block(input logic [15:0] a, input int n,
                             input logic lock);
    logic [15:0] p;
    sent.delete();
    for (int i = 0; i < n; i++) begin
      sent.push_back(8'($urandom));
      p = {a[15:7], 7'(a[6:0] + 7'(i))};
      if (!lock) shadow[p] = sent[i];
    end
    protect_writes = lock;
    run(op_write, strap, a, 8'(n), 0);
    check({7'h_00, err}, 8'h_00);
  endtask : write_block
  task automatic read_check(input op_type op, input logic [15:0] a,
                            input int n, input int stall);
    run(op, strap, a, 8'(n), stall);
    check({7'h_00, err}, 8'h_00);
    check(8'(got.size()), 8'(n));
    foreach (got[i]) check(got[i], expect_at(a + 16'(i)));
  endtask : read_check
  initial begin
    #1_800_000;
    bad_count++;
    end_of_test();
  end
  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    logic [15:0] a;
    reset = 1'b1;
    void'($urandom(32'h_8d0d_cdc4));
    repeat (8) @(posedge core_clk);
    #1 reset = 1'b0;
    for (int t = 0; t < 2; t++) begin
      a = 16'($urandom);
      write_block(a, $urandom_range(6, 1), 1'b0);
      read_check(op_random_read, a, 6, 0);
      $display("random write and read %0d finished", t);
    end
    a = {9'($urandom), 7'h_7e};
    write_block(a, 4, 1'b0);
    read_check(op_random_read, {a[15:7], 7'h_00}, 2, 0);
    read_check(op_random_read, a, 2, 0);
    $display("page wrap finished");
    read_check(op_random_read, 16'h_ffff, 3, 0);
    read_check(op_current_read, 16'h_0002, 2, 0);
    $display("address wrap finished");
    write_block(16'h_0100, 2, 1'b1);
    read_check(op_random_read, 16'h_0100, 2, 0);
    read_check(op_random_read, 16'h_0200, 6, 3000);
    $display("protect and stall finished");
    run(op_current_read, ~strap, 16'h_0000, 8'h_01, 0);
    check({7'h_00, err}, 8'h_01);
    run(op_poll, strap, 16'h_0000, 8'h_01, 0);
    check({7'h_00, err}, 8'h_00);
    run(op_recover, strap, 16'h_0000, 8'h_01, 0);
    check({7'h_00, err}, 8'h_00);
    read_check(op_current_read, 16'h_0206, 1, 0);
    $display("select, poll and recovery finished");
    end_of_test();
  end
endmodule : eeprom_host_tb
`default_nettype wire
